// ### hdl/dams_aux_align.sv
/*
 * Auxiliary output alignment: while the primary runs, holds each auxiliary result until the next
 * primary output instant, and discards results after an auxiliary restart
 * until the primary has produced ALIGN_SKIP outputs.
 * Assumes single-cycle done pulses in the core clock domain.
 */
`timescale 1ns/100ps
module dams_aux_align (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// Events
	input  wire logic auxRestart,
	input  wire logic primActive,
	input  wire logic primOutput,
	input  wire logic auxOutput,
	// Aligned result strobe
	output logic      auxAccept
);

	logic [1:0] primCount_q;
	logic [1:0] primCount_d;
	logic       held_q;
	logic       held_d;
	wire        aligned = (primCount_q >= dams_pkg::ALIGN_SKIP);

	// Without a running primary there is nothing to align to
	assign auxAccept = primActive ? (held_q & primOutput & aligned) : auxOutput; // RL14

	assign primCount_d = auxRestart ? 2'h0 :
		(primOutput && !aligned) ? primCount_q + 2'h1 : primCount_q;
	assign held_d = auxRestart ? 1'b0 :
		(primActive & auxOutput & aligned) ? 1'b1 :
		auxAccept ? 1'b0 : held_q;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			primCount_q <= 2'h0;
			held_q      <= 1'b0;
		end else begin
			primCount_q <= primCount_d;
			held_q      <= held_d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_aux_at_prim_instant;
		(auxAccept && primActive) |-> primOutput && $past(held_q || auxOutput);
	endproperty
	a_aux_at_prim_instant: assert property (p_aux_at_prim_instant) // RL14
		else $error("auxiliary result released off a primary instant");

endmodule

// ### hdl/dams_pkg.sv
/*
 * Shared constants and types of the dual converter mode sequencer.
 * Assumes an 8-bit special function register space.
 * Each access is decoded in the core clock domain.
 */
package dams_pkg;

	// Register addresses in the special function register space
	localparam logic [7:0] MODE_ADDR = 8'hD1;
	localparam logic [7:0] PCTL_ADDR = 8'hD2;
	localparam logic [7:0] ACTL_ADDR = 8'hD3;
	localparam logic [7:0] STAT_ADDR = 8'hD8;

	// Mode control register layout and reset value
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] MODE_WMASK = 8'h37;
	localparam int         PEN_BIT    = 5;
	localparam int         AEN_BIT    = 4;

	// Status register layout and reset value
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam int         ST_PRDY    = 7;
	localparam int         ST_ARDY    = 6;
	localparam int         ST_CAL     = 5;
	localparam int         ST_NOREF   = 4;
	localparam int         ST_PERR    = 3;
	localparam int         ST_AERR    = 2;

	// Primary outputs the auxiliary result waits for after its restart
	localparam logic [1:0] ALIGN_SKIP = 2'h1;

	typedef enum logic [2:0] {
		MD_PDOWN  = 3'h0,
		MD_IDLE   = 3'h1,
		MD_SINGLE = 3'h2,
		MD_CONT   = 3'h3,
		MD_CAL_IZ = 3'h4,
		MD_CAL_IF = 3'h5,
		MD_CAL_SZ = 3'h6,
		MD_CAL_SF = 3'h7
	} dams_mode_t;

	typedef enum logic [1:0] {
		ROUTE_PINS    = 2'h0,
		ROUTE_SHORT   = 2'h1,
		ROUTE_REF_INT = 2'h2,
		ROUTE_REF_EXT = 2'h3
	} dams_route_t;

endpackage

// ### hdl/dams_sequencer.sv
/*
 * Mode sequencer for a primary and an auxiliary sigma-delta converter,
 * with the mode control and status registers on the processor's
 * special function register port.
 * Assumes done and clamp pulses from the converter filters, one cycle each,
 * synchronous to core_clk; control register storage lives elsewhere.
 */
`timescale 1ns/100ps
// Behaviour
// RL1: Mode register resets to all zeros
// RL2: Bit 5 enables primary in shared mode
// RL3: Bit 4 enables auxiliary in shared mode
// RL4: Idle holds filter, modulator reset, clocks run
// RL5: Single conversion updates, flags, returns power-down
// RL6: Continuous mode keeps updating results
// RL7: Internal zero calibration shorts the inputs
// RL8: Internal full calibration routes chosen reference
// RL9: System calibrations sample selected input pins
// RL10: Mode change resets both converters
// RL11: Unchanged mode write also resets both
// RL12: Primary control write or enable rise resets both
// RL13: Auxiliary control write or rise resets auxiliary
// RL14: Auxiliary results align to primary output instants
// RL15: Calibration write clears both ready flags
// RL16: Calibration end writes coefficients, returns power-down
// RL17: Auxiliary calibration on temperature sensor fails
// RL18: Calibrations force maximum decimation factor
// RL19: Set primary ready blocks further primary writes
// RL20: Starting write clears calibration and error flags
// RL21: Clamped primary result sets primary error
// RL22: Reserved mode bits read zero, ignore writes
module dams_sequencer (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// Special function register port
	input  wire logic [7:0]  sfrAddr,
	input  wire logic        sfrWr,
	input  wire logic [7:0]  sfrWrData,
	output logic [7:0]       sfrRdData,
	// Converter events and selections
	input  wire logic        primDone,
	input  wire logic        primClamp,
	input  wire logic        auxDone,
	input  wire logic        auxClamp,
	input  wire logic        auxTempSel,
	input  wire logic        primRefExt,
	input  wire logic        auxRefExt,
	input  wire logic        noExtRef,
	// Converter control
	output logic             primEnable,
	output logic             auxEnable,
	output logic             primModClkEn,
	output logic             auxModClkEn,
	output logic             primHoldReset,
	output logic             auxHoldReset,
	output logic             primRestart,
	output logic             auxRestart,
	output logic [1:0]       primRoute,
	output logic [1:0]       auxRoute,
	output logic             forceMaxDecim,
	// Result and coefficient strobes
	output logic             primResultWr,
	output logic             auxResultWr,
	output logic             primCoefWr,
	output logic             auxCoefWr,
	output logic             coefIsGain
);

	function automatic logic [1:0] route_for(input logic [2:0] md, input logic refExt);
		logic [1:0] r;
		r = dams_pkg::ROUTE_PINS;
		if (md == dams_pkg::MD_CAL_IZ)
			r = dams_pkg::ROUTE_SHORT;
		else if (md == dams_pkg::MD_CAL_IF)
			r = refExt ? dams_pkg::ROUTE_REF_EXT : dams_pkg::ROUTE_REF_INT;
		return r;
	endfunction

	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [7:0] stat_q;
	logic [7:0] stat_d;
	logic [7:0] rd_q;
	logic       pend0_q;
	logic       pend0_d;
	logic       pend1_q;
	logic       pend1_d;
	logic       primRestart_q;
	logic       auxRestart_q;
	logic       auxAccept;

	// Decode
	wire        modeWr = sfrWr && (sfrAddr == dams_pkg::MODE_ADDR);
	wire        statWr = sfrWr && (sfrAddr == dams_pkg::STAT_ADDR);
	wire        pctlWr = sfrWr && (sfrAddr == dams_pkg::PCTL_ADDR);
	wire        actlWr = sfrWr && (sfrAddr == dams_pkg::ACTL_ADDR);
	wire [7:0]  newMode = sfrWrData & dams_pkg::MODE_WMASK; // RL22
	wire [2:0]  md = mode_q[2:0];
	wire [2:0]  newMd = newMode[2:0];
	wire        pEn = mode_q[dams_pkg::PEN_BIT];
	wire        aEn = mode_q[dams_pkg::AEN_BIT];
	wire        isCal = md[2];
	wire        isOneShot = (md == dams_pkg::MD_SINGLE) || isCal;
	wire        prdy = stat_q[dams_pkg::ST_PRDY];
	wire        ardy = stat_q[dams_pkg::ST_ARDY];

	// Reset requests; an auxiliary enable rise alone spares the primary
	wire        aRise = modeWr && newMode[dams_pkg::AEN_BIT] && !aEn;
	wire        auxOnly = modeWr && aRise &&
		((newMode ^ mode_q) == (8'h01 << dams_pkg::AEN_BIT)); // RL13
	wire        bothReset = (modeWr && !auxOnly) || (pctlWr && pEn); // RL10 RL11 RL12
	wire        auxReset = bothReset || auxOnly || actlWr; // RL13
	wire        startWr = modeWr && (newMd >= dams_pkg::MD_SINGLE);
	wire        calWr = modeWr && newMd[2];

	// Converter activity and accepted results
	wire        primActive = pEn && (md == dams_pkg::MD_CONT || (isOneShot && pend0_q));
	wire        auxActive = aEn && (md == dams_pkg::MD_CONT || (isOneShot && pend1_q));
	wire        primOutput = primDone && primActive;
	wire        primAccept = primOutput && !prdy; // RL19
	wire        auxOutput = auxDone && auxActive && !ardy;
	wire        auxCalFail = auxAccept && isCal && auxTempSel; // RL17
	wire        opDone = isOneShot && !modeWr && (pend0_q || pend1_q) && !pend0_d && !pend1_d;

	dams_aux_align u_align (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.auxRestart (auxReset),
		.primActive (primActive),
		.primOutput (primOutput),
		.auxOutput  (auxOutput),
		.auxAccept  (auxAccept)
	);

	// Pending converters of a single conversion or calibration
	assign pend0_d = modeWr ?
		(startWr && newMode[dams_pkg::PEN_BIT] && newMd != dams_pkg::MD_CONT) :
		(primAccept ? 1'b0 : pend0_q);
	assign pend1_d = auxOnly ? isOneShot :
		modeWr ? (startWr && newMode[dams_pkg::AEN_BIT] && newMd != dams_pkg::MD_CONT) :
		(auxAccept ? 1'b0 : pend1_q);

	// Software write wins over a completion in the same cycle
	assign mode_d = modeWr ? newMode :
		opDone ? {mode_q[7:3], dams_pkg::MD_PDOWN} : mode_q; // RL5 RL16

	// Hardware set wins over a software clear of the same flag
	always_comb begin
		stat_d = stat_q;
		if (statWr)
			stat_d = stat_q & sfrWrData;
		if (startWr) begin
			stat_d[dams_pkg::ST_PRDY] = 1'b0; // RL15
			stat_d[dams_pkg::ST_ARDY] = 1'b0; // RL15
			stat_d[dams_pkg::ST_CAL]  = 1'b0; // RL20
			stat_d[dams_pkg::ST_PERR] = 1'b0; // RL20
			stat_d[dams_pkg::ST_AERR] = 1'b0; // RL20
		end
		if (primAccept)
			stat_d[dams_pkg::ST_PRDY] = 1'b1; // RL5
		if (auxAccept)
			stat_d[dams_pkg::ST_ARDY] = 1'b1; // RL17
		if (opDone && isCal)
			stat_d[dams_pkg::ST_CAL] = 1'b1; // RL16
		if (primResultWr && primClamp)
			stat_d[dams_pkg::ST_PERR] = 1'b1; // RL21
		if ((auxResultWr && auxClamp) || auxCalFail)
			stat_d[dams_pkg::ST_AERR] = 1'b1; // RL17
		stat_d[dams_pkg::ST_NOREF] = 1'b0;
		stat_d[1:0] = 2'h0;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_q        <= dams_pkg::MODE_RESET; // RL1
			stat_q        <= dams_pkg::STAT_RESET;
			pend0_q       <= 1'b0;
			pend1_q       <= 1'b0;
			primRestart_q <= 1'b0;
			auxRestart_q  <= 1'b0;
			rd_q          <= 8'h00;
		end else begin
			mode_q        <= mode_d;
			stat_q        <= stat_d;
			pend0_q       <= pend0_d;
			pend1_q       <= pend1_d;
			primRestart_q <= bothReset; // RL10 RL12
			auxRestart_q  <= auxReset; // RL13
			rd_q          <= (sfrAddr == dams_pkg::MODE_ADDR) ? mode_q :
				(sfrAddr == dams_pkg::STAT_ADDR) ?
				(stat_q | ({7'h00, noExtRef} << dams_pkg::ST_NOREF)) : 8'h00;
		end
	end

	assign sfrRdData     = rd_q;
	assign primEnable    = pEn; // RL2
	assign auxEnable     = aEn; // RL3
	assign primModClkEn  = pEn && (md != dams_pkg::MD_PDOWN); // RL4
	assign auxModClkEn   = aEn && (md != dams_pkg::MD_PDOWN); // RL4
	assign primHoldReset = primRestart_q || (pEn && md == dams_pkg::MD_IDLE); // RL4
	assign auxHoldReset  = auxRestart_q || (aEn && md == dams_pkg::MD_IDLE); // RL4
	assign primRestart   = primRestart_q;
	assign auxRestart    = auxRestart_q;
	assign primRoute     = route_for(md, primRefExt); // RL7 RL8 RL9
	assign auxRoute      = route_for(md, auxRefExt); // RL7 RL8 RL9
	assign forceMaxDecim = isCal && (pend0_q || pend1_q); // RL18
	assign primResultWr  = primAccept && !isCal; // RL5 RL6
	assign auxResultWr   = auxAccept && !isCal; // RL6
	assign primCoefWr    = primAccept && isCal; // RL16
	assign auxCoefWr     = auxAccept && isCal && !auxTempSel; // RL16 RL17
	assign coefIsGain    = md[0];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_last_result;
		isOneShot && (pend0_q || pend1_q) && !pend0_d && !pend1_d && !modeWr;
	endsequence
	sequence s_back_to_pdown;
		##1 (md == dams_pkg::MD_PDOWN);
	endsequence

	property p_reserved_zero;
		(mode_q & ~dams_pkg::MODE_WMASK) == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // RL22
		else $error("reserved mode bits not zero");

	property p_enables;
		modeWr |=> primEnable == $past(sfrWrData[5]) && auxEnable == $past(sfrWrData[4]);
	endproperty
	a_enables: assert property (p_enables) // RL2
		else $error("enable outputs do not follow the written bits");

	property p_idle_hold;
		(pEn && md == dams_pkg::MD_IDLE) |-> primHoldReset && primModClkEn;
	endproperty
	a_idle_hold: assert property (p_idle_hold) // RL4
		else $error("idle primary not held with clocks running");

	property p_single_end;
		(md == dams_pkg::MD_SINGLE) and s_last_result |-> s_back_to_pdown;
	endproperty
	a_single_end: assert property (p_single_end) // RL5
		else $error("single conversion did not return to power-down");

	property p_cont_update;
		(md == dams_pkg::MD_CONT && pEn && primDone && !prdy) |-> primResultWr;
	endproperty
	a_cont_update: assert property (p_cont_update) // RL6
		else $error("continuous result not written");

	property p_short_route;
		(md == dams_pkg::MD_CAL_IZ) |-> primRoute == dams_pkg::ROUTE_SHORT
			&& auxRoute == dams_pkg::ROUTE_SHORT;
	endproperty
	a_short_route: assert property (p_short_route) // RL7
		else $error("internal short not routed");

	property p_ref_route;
		(md == dams_pkg::MD_CAL_IF) |->
			primRoute == (primRefExt ? dams_pkg::ROUTE_REF_EXT : dams_pkg::ROUTE_REF_INT);
	endproperty
	a_ref_route: assert property (p_ref_route) // RL8
		else $error("reference not routed for full-scale calibration");

	property p_sys_route;
		(md >= dams_pkg::MD_CAL_SZ) |-> primRoute == dams_pkg::ROUTE_PINS
			&& auxRoute == dams_pkg::ROUTE_PINS;
	endproperty
	a_sys_route: assert property (p_sys_route) // RL9
		else $error("system calibration not on input pins");

	property p_mode_reset;
		(modeWr && !auxOnly) |=> primRestart && auxRestart && primHoldReset && auxHoldReset;
	endproperty
	a_mode_reset: assert property (p_mode_reset) // RL10 RL11
		else $error("mode write did not restart both converters");

	property p_pctl_reset;
		(pctlWr && pEn) |=> primRestart && auxRestart;
	endproperty
	a_pctl_reset: assert property (p_pctl_reset) // RL12
		else $error("primary control write did not restart both");

	property p_aux_only;
		((actlWr || auxOnly) && !bothReset) |=> auxRestart && !primRestart;
	endproperty
	a_aux_only: assert property (p_aux_only) // RL13
		else $error("auxiliary request disturbed the primary");

	property p_cal_clears_ready;
		(calWr && !primAccept && !auxAccept) |=> !prdy && !ardy;
	endproperty
	a_cal_clears_ready: assert property (p_cal_clears_ready) // RL15
		else $error("calibration write left a ready flag set");

	property p_cal_end;
		isCal and s_last_result |-> s_back_to_pdown and ##1 stat_q[dams_pkg::ST_CAL];
	endproperty
	a_cal_end: assert property (p_cal_end) // RL16
		else $error("calibration end not flagged or not powered down");

	property p_temp_fail;
		auxCalFail |-> !auxCoefWr ##1 ardy && stat_q[dams_pkg::ST_AERR];
	endproperty
	a_temp_fail: assert property (p_temp_fail) // RL17
		else $error("auxiliary calibration on temperature sensor not failed");

	property p_max_decim;
		(calWr && (newMode[dams_pkg::PEN_BIT] || newMode[dams_pkg::AEN_BIT])) |=> forceMaxDecim;
	endproperty
	a_max_decim: assert property (p_max_decim) // RL18
		else $error("calibration without maximum decimation");

	property p_ready_blocks;
		prdy |-> !primResultWr && !primCoefWr;
	endproperty
	a_ready_blocks: assert property (p_ready_blocks) // RL19
		else $error("primary wrote while ready set");

	property p_start_clears;
		startWr |=> !stat_q[dams_pkg::ST_CAL] && (!stat_q[dams_pkg::ST_PERR] || $past(primResultWr));
	endproperty
	a_start_clears: assert property (p_start_clears) // RL20
		else $error("start write left status flags set");

	property p_clamp_err;
		(primResultWr && primClamp) |=> stat_q[dams_pkg::ST_PERR] [*1] ##0 prdy;
	endproperty
	a_clamp_err: assert property (p_clamp_err) // RL21
		else $error("clamped primary result not flagged");

endmodule

// ### verif/tb_top.sv
/*
 * Self-checking bench for the dual converter mode sequencer.
 * Assumes the sequencer carries its own assertions and that the bench
 * alone drives every port, standing in for the core and the filters.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
	// Clock and reset
	logic       core_clk;
	logic       rstn;
	// Register port
	logic [7:0] sfrAddr;
	logic       sfrWr;
	logic [7:0] sfrWrData;
	logic [7:0] sfrRdData;
	// Converter events and selections
	logic       primDone;
	logic       primClamp;
	logic       auxDone;
	logic       auxClamp;
	logic       auxTempSel;
	logic       primRefExt;
	logic       auxRefExt;
	logic       noExtRef;
	// Converter control and strobes
	logic       primEnable;
	logic       auxEnable;
	logic       primModClkEn;
	logic       auxModClkEn;
	logic       primHoldReset;
	logic       auxHoldReset;
	logic       primRestart;
	logic       auxRestart;
	logic [1:0] primRoute;
	logic [1:0] auxRoute;
	logic       forceMaxDecim;
	logic       primResultWr;
	logic       auxResultWr;
	logic       primCoefWr;
	logic       auxCoefWr;
	logic       coefIsGain;
	int         miscompares;
	int         n_compared;
	logic       pw, aw, pc, ac, gn;
	logic [7:0] rv;

	dams_sequencer u_dut (.core_clk(core_clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
		.sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .primDone(primDone),
		.primClamp(primClamp), .auxDone(auxDone), .auxClamp(auxClamp),
		.auxTempSel(auxTempSel), .primRefExt(primRefExt), .auxRefExt(auxRefExt),
		.noExtRef(noExtRef), .primEnable(primEnable), .auxEnable(auxEnable),
		.primModClkEn(primModClkEn), .auxModClkEn(auxModClkEn),
		.primHoldReset(primHoldReset), .auxHoldReset(auxHoldReset),
		.primRestart(primRestart), .auxRestart(auxRestart), .primRoute(primRoute),
		.auxRoute(auxRoute), .forceMaxDecim(forceMaxDecim), .primResultWr(primResultWr),
		.auxResultWr(auxResultWr), .primCoefWr(primCoefWr), .auxCoefWr(auxCoefWr),
		.coefIsGain(coefIsGain));

	always #25 core_clk = ~core_clk;

	// Expected input routing for a calibration mode
	function automatic logic [1:0] expRoute(input logic [2:0] m, input logic ext);
		if (m == 3'h4)
			return 2'h1;
		if (m == 3'h5)
			return ext ? 2'h3 : 2'h2;
		return 2'h0;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfrAddr   <= a;
		sfrWrData <= d;
		sfrWr     <= 1'b1;
		@(posedge core_clk);
		sfrWr     <= 1'b0;
		@(negedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
		@(posedge core_clk);
		sfrAddr <= a;
		@(posedge core_clk);
		@(negedge core_clk);
		`CHK(nm, ex, sfrRdData)
	endtask

	// One filter output cycle; strobes are sampled while the pulse stands
	task automatic dn(input logic p, input logic a, input logic cl);
		@(posedge core_clk);
		primDone  <= p;
		auxDone   <= a;
		primClamp <= cl;
		@(negedge core_clk);
		pw = primResultWr;
		aw = auxResultWr;
		pc = primCoefWr;
		ac = auxCoefWr;
		gn = coefIsGain;
		@(posedge core_clk);
		primDone  <= 1'b0;
		auxDone   <= 1'b0;
		primClamp <= 1'b0;
	endtask

	task automatic restartChk(input logic [7:0] a, input logic [7:0] d, input logic p,
		input logic x);
		wr(a, d);
		`CHK("primRestart", p, primRestart)
		`CHK("auxRestart", x, auxRestart)
	endtask

	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		miscompares++;
		test_done();
	end

	initial begin
		logic [7:0] v;
		logic       ext;
		int         hits;
		core_clk = 1'b0;
		rstn = 1'b0;
		{sfrAddr, sfrWr, sfrWrData, primDone, primClamp, auxDone, auxClamp} = '0;
		{auxTempSel, primRefExt, auxRefExt, noExtRef} = '0;
		miscompares = 0;
		n_compared = 0;
		void'($urandom(30447));
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		rd(dams_pkg::MODE_ADDR, 8'h00, "modeReset");
		rd(dams_pkg::STAT_ADDR, 8'h00, "statReset");
		`CHK("primModClkEn", 1'b0, primModClkEn)
		$display("end of test reset");
		// Idle with random enables and reserved bits
		for (int i = 0; i < 6; i++) begin
			v = (8'($urandom()) & 8'hF8) | 8'h01;
			@(posedge core_clk);
			auxRefExt <= 1'($urandom());
			wr(dams_pkg::MODE_ADDR, v);
			@(negedge core_clk);
			rd(dams_pkg::MODE_ADDR, v & 8'h37, "modeReadback");
			`CHK("primEnable", v[5], primEnable)
			`CHK("auxEnable", v[4], auxEnable)
			`CHK("primHoldReset", v[5], primHoldReset)
			`CHK("primModClkEn", v[5], primModClkEn)
			`CHK("auxHoldReset", v[4], auxHoldReset)
			`CHK("auxModClkEn", v[4], auxModClkEn)
		end
		wr(dams_pkg::MODE_ADDR, 8'h30);
		@(negedge core_clk);
		`CHK("primModClkEnDown", 1'b0, primModClkEn)
		`CHK("auxModClkEnDown", 1'b0, auxModClkEn)
		$display("end of test idle");
		restartChk(dams_pkg::MODE_ADDR, 8'h23, 1'b1, 1'b1);
		restartChk(dams_pkg::MODE_ADDR, 8'h23, 1'b1, 1'b1);
		restartChk(dams_pkg::MODE_ADDR, 8'h33, 1'b0, 1'b1);
		restartChk(dams_pkg::PCTL_ADDR, 8'h07, 1'b1, 1'b1);
		restartChk(dams_pkg::ACTL_ADDR, 8'h00, 1'b0, 1'b1);
		restartChk(dams_pkg::MODE_ADDR, 8'h00, 1'b1, 1'b1);
		restartChk(dams_pkg::MODE_ADDR, 8'h20, 1'b1, 1'b1);
		$display("end of test restart");
		wr(dams_pkg::MODE_ADDR, 8'h22);
		dn(1'b1, 1'b0, 1'b1);
		`CHK("singleResultWr", 1'b1, pw)
		rd(dams_pkg::MODE_ADDR, 8'h20, "singleModeBack");
		rd(dams_pkg::STAT_ADDR, 8'h88, "singleStatus");
		wr(dams_pkg::MODE_ADDR, 8'h23);
		rd(dams_pkg::STAT_ADDR, 8'h00, "startClears");
		dn(1'b1, 1'b0, 1'b0);
		`CHK("contResultWr", 1'b1, pw)
		dn(1'b1, 1'b0, 1'b0);
		`CHK("blockedResultWr", 1'b0, pw)
		wr(dams_pkg::STAT_ADDR, 8'h7F);
		dn(1'b1, 1'b0, 1'b0);
		`CHK("contResultWrAgain", 1'b1, pw)
		$display("end of test conversion");
		for (int m = 4; m < 8; m++) begin
			ext = 1'($urandom());
			@(posedge core_clk);
			primRefExt <= ext;
			auxRefExt  <= ~ext;
			wr(dams_pkg::MODE_ADDR, 8'h20 | 8'(m));
			`CHK("primRoute", expRoute(3'(m), ext), primRoute)
			`CHK("auxRouteCal", expRoute(3'(m), ~ext), auxRoute)
			`CHK("forceMaxDecim", 1'b1, forceMaxDecim)
			rd(dams_pkg::STAT_ADDR, 8'h00, "calStartStatus");
			dn(1'b1, 1'b0, 1'b0);
			`CHK("primCoefWr", 1'b1, pc)
			`CHK("coefIsGain", 1'(m), gn)
			rd(dams_pkg::MODE_ADDR, 8'h20, "calModeBack");
			rd(dams_pkg::STAT_ADDR, 8'hA0, "calStatus");
			`CHK("forceMaxDecimEnd", 1'b0, forceMaxDecim)
		end
		@(posedge core_clk);
		auxTempSel <= 1'b1;
		wr(dams_pkg::MODE_ADDR, 8'h14);
		`CHK("auxRoute", 2'h1, auxRoute)
		dn(1'b0, 1'b1, 1'b0);
		`CHK("tempAuxCoefWr", 1'b0, ac)
		rd(dams_pkg::STAT_ADDR, 8'h64, "tempCalStatus");
		rd(dams_pkg::MODE_ADDR, 8'h10, "tempCalMode");
		@(posedge core_clk);
		auxTempSel <= 1'b0;
		wr(dams_pkg::MODE_ADDR, 8'h17);
		`CHK("auxRouteSys", 2'h0, auxRoute)
		dn(1'b0, 1'b1, 1'b0);
		`CHK("auxCoefWr", 1'b1, ac)
		rd(dams_pkg::STAT_ADDR, 8'h60, "auxCalStatus");
		$display("end of test calibration");
		wr(dams_pkg::MODE_ADDR, 8'h33);
		hits = 0;
		for (int i = 0; i < 3; i++) begin
			dn(1'b0, 1'b1, 1'b0);
			`CHK("auxHeld", 1'b0, aw)
			dn(1'b1, 1'b0, 1'b0);
			hits += int'(aw === 1'b1);
			wr(dams_pkg::STAT_ADDR, 8'h00);
		end
		`CHK("alignedRelease", 3 - int'(dams_pkg::ALIGN_SKIP), hits)
		// Clamped auxiliary result and a missing reference both show in status
		@(posedge core_clk);
		noExtRef <= 1'b1;
		auxClamp <= 1'b1;
		dn(1'b0, 1'b1, 1'b0);
		dn(1'b1, 1'b0, 1'b0);
		`CHK("clampedAuxWr", 1'b1, aw)
		rd(dams_pkg::STAT_ADDR, 8'hD4, "clampStatus");
		$display("end of test alignment");
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		rd(dams_pkg::MODE_ADDR, 8'h00, "modeMidReset");
		rd(dams_pkg::STAT_ADDR, 8'h10, "statMidReset");
		`CHK("primEnableMidReset", 1'b0, primEnable)
		`CHK("auxEnableMidReset", 1'b0, auxEnable)
		$display("end of test mid reset");
		test_done();
	end
endmodule
